//--- rtl/acc_cfg.svh
// acc_cfg.svh: register offsets, field positions, reset values and timing counts
// of the auxiliary converter control; included by every module file of the block.
`ifndef ACC_CFG_SVH
`define ACC_CFG_SVH

`define ACC_OFS_REF       8'h17
`define ACC_OFS_AVG_A     8'h18
`define ACC_OFS_AVG_B     8'h19
`define ACC_OFS_RX        8'h22
`define ACC_OFS_CLKDIV    8'h23
`define ACC_OFS_DAC_A     8'h24
`define ACC_OFS_SPAN      8'h25
`define ACC_OFS_DAC_B     8'h26
`define ACC_OFS_UPD       8'h28
`define ACC_OFS_PWR       8'h29
`define ACC_OFS_RES_BASE  8'h2a
`define ACC_OFS_RES_LAST  8'h2f

`define ACC_RST_REF       8'h00
`define ACC_RST_AVG       4'h0
`define ACC_RST_RX        8'h00
`define ACC_RST_CLKDIV    6'h02
`define ACC_RST_SPAN      2'h0
`define ACC_RST_DAC       10'h000
`define ACC_RST_UPD       4'h0
`define ACC_RST_PWR       3'h0

`define ACC_BIT_START_A   0
`define ACC_BIT_EXTREF_A  1
`define ACC_BIT_START_B   3
`define ACC_BIT_AVG_START 7
`define ACC_BIT_AVG_EN    3
`define ACC_BIT_REF_FS    0
`define ACC_BIT_REF_EN    1
`define ACC_BIT_EXTREF_B  2
`define ACC_BIT_SEL_A     2
`define ACC_BIT_SLAVE     7

`define ACC_CONV_TICKS    16
`define ACC_AVG_MAX_CODE  3'h5
`define ACC_SLOT_A_PIN1   2'h0
`define ACC_SLOT_A_PIN2   2'h1
`define ACC_SLOT_B        2'h2

`endif

//--- rtl/acc_pkg.sv
// acc_pkg: types shared by the auxiliary converter control files.
// assumes acc_cfg.svh supplies the numeric constants.
package acc_pkg;
  typedef enum logic [0:0] {SEQ_IDLE, SEQ_CONV} acc_seq_e;
  typedef enum logic [1:0] {UPD_IMMEDIATE, UPD_ON_WRITE, UPD_ON_TXPD} acc_upd_e;
  typedef enum logic [1:0] {MODE_REG, MODE_EXT_START, MODE_AUX_PORT} acc_mode_e;
  typedef logic [9:0] acc_code_t;
endpackage

//--- rtl/acc_result_mem.sv
// acc_result_mem: three 10-bit result slots, two write ports, registered read.
// assumes the two writers never aim at the same slot in one cycle.
`timescale 1ns/1ps
`include "acc_cfg.svh"
module acc_result_mem
  import acc_pkg::*;
(
  input  wire logic      clk_sys_i,
  input  wire logic      rstn_i,
  input  wire logic      wa_en_i,
  input  wire logic [1:0] wa_idx_i,
  input  wire acc_code_t wa_data_i,
  input  wire logic      wb_en_i,
  input  wire logic [1:0] wb_idx_i,
  input  wire acc_code_t wb_data_i,
  input  wire logic [1:0] rd_idx_i,
  output acc_code_t      rd_data_o
);
  acc_code_t slot_r [3];

  // whole 10-bit word written at once so both byte halves change together
  genvar i;
  for (i = 0; i < 3; i++) begin : g_slot
    always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
        slot_r[i] <= `ACC_RST_DAC;
      end else if (wa_en_i && wa_idx_i == 2'(i)) begin
        slot_r[i] <= wa_data_i;
      end else if (wb_en_i && wb_idx_i == 2'(i)) begin
        slot_r[i] <= wb_data_i;
      end
    end

    slot_keep_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      !(wa_en_i && wa_idx_i == 2'(i)) && !(wb_en_i && wb_idx_i == 2'(i)) |=> $stable(slot_r[i]))
      else $error("result slot changed without a write");
  end

  // registered read; index 3 is not a slot and reads zero
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      rd_data_o <= `ACC_RST_DAC;
    end else begin
      rd_data_o <= (rd_idx_i == 2'h3) ? `ACC_RST_DAC : slot_r[rd_idx_i];
    end
  end
endmodule

//--- rtl/acc_sar_seq.sv
// acc_sar_seq: one auxiliary ADC sequencer; powers the SAR, counts sixteen
// converter ticks, and averages when asked. assumes sample_i is already synchronised
// and settled by the last tick of a conversion.
`timescale 1ns/1ps
`include "acc_cfg.svh"
module acc_sar_seq
  import acc_pkg::*;
(
  input  wire logic      clk_sys_i,
  input  wire logic      rstn_i,
  input  wire logic      tick_i,
  input  wire logic      start_i,
  input  wire logic      avg_en_i,
  input  wire logic [2:0] avg_code_i,
  input  wire acc_code_t sample_i,
  output logic           busy_o,
  output logic           done_o,
  output acc_code_t      result_o
);
  acc_seq_e    state_r;
  logic [3:0]  tick_cnt_r;
  logic [5:0]  samp_cnt_r;
  logic [15:0] acc_r;
  logic [2:0]  code;
  logic [5:0]  samp_last;
  logic [15:0] sum;
  logic        last_tick;
  logic [4:0]  chk_ticks_r;

  // codes above 64 samples are clamped rather than left undefined
  assign code      = (avg_code_i > `ACC_AVG_MAX_CODE) ? `ACC_AVG_MAX_CODE : avg_code_i;
  assign samp_last = 6'((7'h2 << code) - 7'h1);
  assign last_tick = (state_r == SEQ_CONV) && tick_i && (tick_cnt_r == 4'(`ACC_CONV_TICKS - 1));
  assign sum       = acc_r + {6'h00, sample_i};
  assign busy_o    = (state_r == SEQ_CONV);

  // converter powers up on request and drops out when idle
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      state_r <= SEQ_IDLE;
    end else begin
      case (state_r)
        SEQ_IDLE: if (start_i) state_r <= SEQ_CONV;
        SEQ_CONV: if (last_tick && !avg_en_i) state_r <= SEQ_IDLE;
        default:  state_r <= SEQ_IDLE;
      endcase
    end
  end

  // tick counter wraps at sixteen so averaging runs back to back
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i || state_r == SEQ_IDLE) begin
      tick_cnt_r <= 4'h0;
    end else if (tick_i) begin
      tick_cnt_r <= tick_cnt_r + 4'h1;
    end
  end

  // accumulator; a partial set is dropped if averaging is turned off
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i || state_r == SEQ_IDLE) begin
      samp_cnt_r <= 6'h00;
      acc_r      <= 16'h0000;
    end else if (last_tick && avg_en_i) begin
      samp_cnt_r <= (samp_cnt_r == samp_last) ? 6'h00 : samp_cnt_r + 6'h01;
      acc_r      <= (samp_cnt_r == samp_last) ? 16'h0000 : sum;
    end
  end

  // result and one-cycle done
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      done_o   <= 1'b0;
      result_o <= `ACC_RST_DAC;
    end else begin
      done_o <= last_tick && (!avg_en_i || samp_cnt_r == samp_last);
      if (last_tick) begin
        result_o <= avg_en_i ? 10'(sum >> (4'(code) + 4'h1)) : sample_i;
      end
    end
  end

  // helper: ticks seen in the current conversion
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i || state_r == SEQ_IDLE || last_tick) begin
      chk_ticks_r <= 5'h00;
    end else if (tick_i) begin
      chk_ticks_r <= chk_ticks_r + 5'h01;
    end
  end

  conv_length_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    done_o && !$past(avg_en_i) |-> $past(chk_ticks_r) == 5'(`ACC_CONV_TICKS - 1))
    else $error("conversion did not span sixteen ticks");
  auto_power_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (state_r == SEQ_IDLE) && start_i |=> busy_o ##0 !done_o)
    else $error("converter did not power up on request");
  avg_continuous_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    last_tick && avg_en_i |=> busy_o)
    else $error("averaging did not keep converting");
  avg_done_c: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) done_o && avg_en_i);
endmodule

//--- rtl/acc_top.sv
// acc_top: control of two auxiliary DACs and two auxiliary SAR ADCs behind the
// serial-port register file. assumes a serial front end presents one-cycle write
// strobes with address and data, and that clk_sys_i is the receive ADC clock.
`timescale 1ns/1ps
`include "acc_cfg.svh"
module acc_top
  import acc_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       rstn_i,
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic       transmit_power_down_signal_i,
  input  wire logic       ext_start_convert_i,
  input  wire acc_code_t  first_aux_adc_sample_i,
  input  wire acc_code_t  second_aux_adc_sample_i,
  output logic      [1:0] regulator_span_o,
  output logic      [2:0] auxiliary_dac_power_o,
  output acc_code_t       first_dac_code_o,
  output acc_code_t       second_dac_code_o,
  output logic      [1:0] first_dac_fullscale_o,
  output logic      [1:0] second_dac_fullscale_o,
  output logic            aux_adc_tick_o,
  output logic      [1:0] auxiliary_adc_power_o,
  output logic            first_adc_input_select_o,
  output logic            internal_reference_enable_o,
  output logic            internal_reference_span_o,
  output logic      [1:0] external_reference_pin_route_o
);
  logic [7:0] ref_r;
  logic [3:0] avg_r [2];
  logic [7:0] rx_r;
  logic [5:0] div_r;
  acc_code_t  dac_a_r;
  acc_code_t  dac_b_r;
  acc_code_t  dac_a_nxt;
  acc_code_t  dac_b_nxt;
  logic [1:0] span_r;
  logic [3:0] upd_r;
  logic [2:0] pwr_r;
  logic [7:0] ctl_rdata_r;
  logic       res_sel_r;
  logic       res_hi_r;
  acc_code_t  res_rd;
  logic [2:0] div_cnt_r;
  logic [2:0] div_last;
  logic       tick;
  logic [1:0] txpd_s_r;
  logic [1:0] exts_s_r;
  logic       txpd_d_r;
  logic       exts_d_r;
  acc_code_t  samp_s1_r [2];
  acc_code_t  samp_s2_r [2];
  logic [1:0] start_ch;
  logic [1:0] busy_ch;
  logic [1:0] done_ch;
  acc_code_t  result_ch [2];
  logic       wr_upd;
  logic       txpd_rise;
  logic       ext_rise;
  logic       apply_a;
  logic       apply_b;
  acc_upd_e   upd_mode;
  acc_mode_e  adc_mode;

  // decoded write strobes
  logic wr_ref, wr_avg_a, wr_avg_b, wr_rx, wr_div, wr_dac_a, wr_span, wr_dac_b, wr_pwr;
  assign wr_ref   = reg_wr_i && reg_addr_i == `ACC_OFS_REF;
  assign wr_avg_a = reg_wr_i && reg_addr_i == `ACC_OFS_AVG_A;
  assign wr_avg_b = reg_wr_i && reg_addr_i == `ACC_OFS_AVG_B;
  assign wr_rx    = reg_wr_i && reg_addr_i == `ACC_OFS_RX;
  assign wr_div   = reg_wr_i && reg_addr_i == `ACC_OFS_CLKDIV;
  assign wr_dac_a = reg_wr_i && reg_addr_i == `ACC_OFS_DAC_A;
  assign wr_span  = reg_wr_i && reg_addr_i == `ACC_OFS_SPAN;
  assign wr_dac_b = reg_wr_i && reg_addr_i == `ACC_OFS_DAC_B;
  assign wr_upd   = reg_wr_i && reg_addr_i == `ACC_OFS_UPD;
  assign wr_pwr   = reg_wr_i && reg_addr_i == `ACC_OFS_PWR;

  // configuration registers; start and update bits are pulses and are not stored
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      ref_r  <= `ACC_RST_REF;
      avg_r  <= '{`ACC_RST_AVG, `ACC_RST_AVG};
      rx_r   <= `ACC_RST_RX;
      div_r  <= `ACC_RST_CLKDIV;
      span_r <= `ACC_RST_SPAN;
      upd_r  <= `ACC_RST_UPD;
      pwr_r  <= `ACC_RST_PWR;
    end else begin
      if (wr_ref) ref_r <= reg_wdata_i;
      if (wr_avg_a) avg_r[0] <= reg_wdata_i[3:0];
      if (wr_avg_b) avg_r[1] <= reg_wdata_i[3:0];
      if (wr_rx) rx_r <= reg_wdata_i & 8'hf6;
      if (wr_div) div_r <= reg_wdata_i[5:0];
      if (wr_span) span_r <= reg_wdata_i[1:0];
      if (wr_upd) upd_r <= reg_wdata_i[7:4];
      if (wr_pwr) pwr_r <= reg_wdata_i[2:0];
    end
  end

  // dac data held here; 0x25 carries the two low bits of both codes
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      dac_a_r <= `ACC_RST_DAC;
      dac_b_r <= `ACC_RST_DAC;
    end else begin
      if (wr_dac_a) dac_a_r[9:2] <= reg_wdata_i;
      if (wr_dac_b) dac_b_r[9:2] <= reg_wdata_i;
      if (wr_span) begin
        dac_a_r[1:0] <= reg_wdata_i[7:6];
        dac_b_r[1:0] <= reg_wdata_i[5:4];
      end
    end
  end
  // code as it stands after this cycle's write, so an immediate apply never loads the stale code
  assign dac_a_nxt = {wr_dac_a ? reg_wdata_i : dac_a_r[9:2], wr_span ? reg_wdata_i[7:6] : dac_a_r[1:0]};
  assign dac_b_nxt = {wr_dac_b ? reg_wdata_i : dac_b_r[9:2], wr_span ? reg_wdata_i[5:4] : dac_b_r[1:0]};

  // pins cross two flops before any logic; the edge detect reads the second
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      txpd_s_r <= 2'h0;
      exts_s_r <= 2'h0;
      txpd_d_r <= 1'b0;
      exts_d_r <= 1'b0;
    end else begin
      txpd_s_r <= {txpd_s_r[0], transmit_power_down_signal_i};
      exts_s_r <= {exts_s_r[0], ext_start_convert_i};
      txpd_d_r <= txpd_s_r[1];
      exts_d_r <= exts_s_r[1];
    end
  end
  assign txpd_rise = txpd_s_r[1] && !txpd_d_r;
  assign ext_rise  = exts_s_r[1] && !exts_d_r;

  // update-mode decode; the unused code behaves as immediate
  always_comb begin
    case (upd_r[1:0])
      2'h1:    upd_mode = UPD_ON_WRITE;
      2'h2:    upd_mode = UPD_ON_TXPD;
      default: upd_mode = UPD_IMMEDIATE;
    endcase
  end

  // slave mode wins over the sync mode; writing the code alone never moves a held output
  always_comb begin
    if (upd_r[`ACC_BIT_SLAVE - 4]) begin
      apply_a = wr_upd && reg_wdata_i[0];
      apply_b = wr_upd && reg_wdata_i[1];
    end else begin
      case (upd_mode)
        UPD_ON_WRITE: begin
          apply_a = wr_upd;
          apply_b = wr_upd;
        end
        UPD_ON_TXPD: begin
          apply_a = txpd_rise;
          apply_b = txpd_rise;
        end
        default: begin
          apply_a = wr_dac_a || wr_span;
          apply_b = wr_dac_b || wr_span;
        end
      endcase
    end
  end

  // dac codes driven to the converters; visible one cycle after the apply
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      first_dac_code_o  <= `ACC_RST_DAC;
      second_dac_code_o <= `ACC_RST_DAC;
    end else begin
      if (apply_a) first_dac_code_o <= dac_a_nxt;
      if (apply_b) second_dac_code_o <= dac_b_nxt;
    end
  end

  // static analog controls straight from flops; the adc power follows the sequencer state
  assign regulator_span_o               = span_r;
  assign auxiliary_dac_power_o          = pwr_r;
  assign first_dac_fullscale_o          = ref_r[5:4];
  assign second_dac_fullscale_o         = ref_r[7:6];
  assign first_adc_input_select_o       = div_r[`ACC_BIT_SEL_A];
  assign internal_reference_enable_o    = ref_r[`ACC_BIT_REF_EN];
  assign internal_reference_span_o      = ref_r[`ACC_BIT_REF_FS];
  assign external_reference_pin_route_o = {ref_r[`ACC_BIT_EXTREF_B], rx_r[`ACC_BIT_EXTREF_A]};
  assign auxiliary_adc_power_o          = busy_ch;

  // adc clock divider: code 00 /1, 01 /2, 10 /4, 11 /8; >= keeps a ratio change safe
  assign div_last = 3'((4'h1 << div_r[1:0]) - 4'h1);
  assign tick     = (div_cnt_r >= div_last);
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i || tick) begin
      div_cnt_r <= 3'h0;
    end else begin
      div_cnt_r <= div_cnt_r + 3'h1;
    end
  end
  assign aux_adc_tick_o = tick;

  // adc mode decode; the auxiliary serial port mode only blocks register starts here
  always_comb begin
    case (div_r[5:4])
      2'h1:    adc_mode = MODE_EXT_START;
      2'h2:    adc_mode = MODE_AUX_PORT;
      default: adc_mode = MODE_REG;
    endcase
  end

  // starts: ordinary bit when not averaging, start-average bit when averaging
  always_comb begin
    start_ch = 2'h0;
    if (adc_mode != MODE_AUX_PORT) begin
      start_ch[0] = avg_r[0][`ACC_BIT_AVG_EN] ? (wr_avg_a && reg_wdata_i[`ACC_BIT_AVG_START])
                                              : (wr_rx && reg_wdata_i[`ACC_BIT_START_A]);
      start_ch[1] = avg_r[1][`ACC_BIT_AVG_EN] ? (wr_avg_b && reg_wdata_i[`ACC_BIT_AVG_START])
                                              : (wr_rx && reg_wdata_i[`ACC_BIT_START_B]);
      if (adc_mode == MODE_EXT_START && ext_rise) begin
        start_ch = 2'h3;
      end
    end
  end

  // per-channel sample synchronisers and sequencers
  genvar ch;
  for (ch = 0; ch < 2; ch++) begin : g_adc
    always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
        samp_s1_r[ch] <= `ACC_RST_DAC;
        samp_s2_r[ch] <= `ACC_RST_DAC;
      end else begin
        samp_s1_r[ch] <= (ch == 0) ? first_aux_adc_sample_i : second_aux_adc_sample_i;
        samp_s2_r[ch] <= samp_s1_r[ch];
      end
    end

    acc_sar_seq u_seq (
      .clk_sys_i (clk_sys_i),
      .rstn_i    (rstn_i),
      .tick_i    (tick),
      .start_i   (start_ch[ch]),
      .avg_en_i  (avg_r[ch][`ACC_BIT_AVG_EN]),
      .avg_code_i(avg_r[ch][2:0]),
      .sample_i  (samp_s2_r[ch]),
      .busy_o    (busy_ch[ch]),
      .done_o    (done_ch[ch]),
      .result_o  (result_ch[ch])
    );
  end

  // slot choice: select low means pin two feeds the first converter
  logic [1:0] slot_a;
  logic [1:0] rd_idx;
  assign slot_a = first_adc_input_select_o ? `ACC_SLOT_A_PIN1 : `ACC_SLOT_A_PIN2;
  assign rd_idx = 2'((reg_addr_i - `ACC_OFS_RES_BASE) >> 1);

  acc_result_mem u_mem (
    .clk_sys_i(clk_sys_i),
    .rstn_i   (rstn_i),
    .wa_en_i  (done_ch[0]),
    .wa_idx_i (slot_a),
    .wa_data_i(result_ch[0]),
    .wb_en_i  (done_ch[1]),
    .wb_idx_i (`ACC_SLOT_B),
    .wb_data_i(result_ch[1]),
    .rd_idx_i (rd_idx),
    .rd_data_o(res_rd)
  );

  // register read, one cycle after the address; unmapped offsets read zero
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      ctl_rdata_r <= 8'h00;
      res_sel_r   <= 1'b0;
      res_hi_r    <= 1'b0;
    end else begin
      res_sel_r <= reg_addr_i >= `ACC_OFS_RES_BASE && reg_addr_i <= `ACC_OFS_RES_LAST;
      res_hi_r  <= reg_addr_i[0];
      case (reg_addr_i)
        `ACC_OFS_REF:    ctl_rdata_r <= ref_r;
        `ACC_OFS_AVG_A:  ctl_rdata_r <= {4'h0, avg_r[0]};
        `ACC_OFS_AVG_B:  ctl_rdata_r <= {4'h0, avg_r[1]};
        `ACC_OFS_RX:     ctl_rdata_r <= rx_r;
        `ACC_OFS_CLKDIV: ctl_rdata_r <= {busy_ch, div_r};
        `ACC_OFS_DAC_A:  ctl_rdata_r <= dac_a_r[9:2];
        `ACC_OFS_SPAN:   ctl_rdata_r <= {dac_a_r[1:0], dac_b_r[1:0], 2'h0, span_r};
        `ACC_OFS_DAC_B:  ctl_rdata_r <= dac_b_r[9:2];
        `ACC_OFS_UPD:    ctl_rdata_r <= {upd_r, 4'h0};
        `ACC_OFS_PWR:    ctl_rdata_r <= {5'h00, pwr_r};
        default:         ctl_rdata_r <= 8'h00;
      endcase
    end
  end
  // even offset of a slot is the low byte, odd the two high bits
  assign reg_rdata_o = !res_sel_r ? ctl_rdata_r : (res_hi_r ? {6'h00, res_rd[9:8]} : res_rd[7:0]);

  // checks
  reset_off_a: assert property (@(posedge clk_sys_i)
    $past(!rstn_i) && rstn_i |-> auxiliary_dac_power_o == 3'h0 && auxiliary_adc_power_o == 2'h0)
    else $error("converters not powered down after reset");
  span_field_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    wr_span |=> regulator_span_o == $past(reg_wdata_i[1:0]))
    else $error("regulator span not taken from write");
  dac_power_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !wr_pwr |=> $stable(auxiliary_dac_power_o))
    else $error("dac power changed without a write");
  dac_immediate_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    wr_dac_a && upd_r == 4'h0 |=> first_dac_code_o[9:2] == $past(reg_wdata_i))
    else $error("immediate dac update missed");
  slave_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    upd_r[3] && !wr_upd |=> $stable(first_dac_code_o) && $stable(second_dac_code_o))
    else $error("dac moved in slave mode without update bit");
  clk_div4_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    tick && div_r[1:0] == 2'h2 ##1 (div_r[1:0] == 2'h2 && !tick) [*3] ##1 div_r[1:0] == 2'h2 |-> tick)
    else $error("divide by four spacing wrong");
  reg_start_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    wr_rx && reg_wdata_i[0] && !avg_r[0][3] && div_r[5:4] == 2'h0 && !busy_ch[0] |=> auxiliary_adc_power_o[0])
    else $error("start bit did not begin a conversion");
  avg_start_only_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !busy_ch[0] && avg_r[0][3] && !wr_avg_a && !(div_r[5:4] == 2'h1 && ext_rise) |=> !busy_ch[0])
    else $error("averaging channel started without start-average");
  slot_route_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    done_ch[0] && !first_adc_input_select_o |=> u_mem.slot_r[1] == $past(result_ch[0]))
    else $error("pin two result not routed to its slot");

  both_start_c: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) start_ch == 2'h3);
  slave_update_c: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) upd_r[3] && apply_a);
  txpd_update_c: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) upd_mode == UPD_ON_TXPD && txpd_rise);
endmodule

//--- testbench/acc_top_test.sv
// acc_top_test: self-checking bench for the auxiliary converter control.
// assumes acc_top alone; the bench drives its write strobe and sample pins.
`timescale 1ns/1ps
module acc_top_test
  import acc_pkg::*;
;
  logic       clk_sys_i = 1'b0;
  logic       rstn_i    = 1'b0;
  logic       wr        = 1'b0;
  logic [7:0] addr      = 8'h00;
  logic [7:0] wdata     = 8'h00;
  logic [7:0] rdata;
  acc_code_t  smp_a     = 10'h000;
  acc_code_t  smp_b     = 10'h000;
  acc_code_t  dac_a;
  logic [1:0] span;
  logic [1:0] adc_pwr;
  logic [2:0] dac_pwr;
  logic       tick;
  logic       sel_a;
  logic       txpd      = 1'b0;
  logic       exts      = 1'b0;
  acc_code_t  dac_b;
  logic [1:0] fs_a;
  logic [1:0] fs_b;
  logic [1:0] route;
  logic       ref_en;
  logic       ref_fs;
  int         err_count = 0;
  int         checks    = 0;

  acc_top i_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .reg_wr_i(wr), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .transmit_power_down_signal_i(txpd),
    .ext_start_convert_i(exts), .first_aux_adc_sample_i(smp_a), .second_aux_adc_sample_i(smp_b),
    .regulator_span_o(span), .auxiliary_dac_power_o(dac_pwr), .first_dac_code_o(dac_a),
    .second_dac_code_o(dac_b), .first_dac_fullscale_o(fs_a), .second_dac_fullscale_o(fs_b),
    .aux_adc_tick_o(tick), .auxiliary_adc_power_o(adc_pwr), .first_adc_input_select_o(sel_a),
    .internal_reference_enable_o(ref_en), .internal_reference_span_o(ref_fs),
    .external_reference_pin_route_o(route));

  // 200 MHz system clock
  initial begin
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one idle cycle after each write, so the strobe never toggles twice in a step
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    wr = 1'b1;
    addr = a;
    wdata = d;
    step(1);
    wr = 1'b0;
    step(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    step(3);
    chk("rdata", {2'b00, exp}, {2'b00, rdata});
  endtask

  task automatic ticks(input int exp);
    int n;
    n = 0;
    repeat (16) begin
      if (tick === 1'b1) n++;
      step(1);
    end
    chk("ticks", exp[9:0], n[9:0]);
  endtask

  // phase of the divider is unknown, so the length is judged within a window of 58 to 67 cycles
  task automatic conv(input logic [7:0] cmd, input logic [1:0] pwr);
    int n;
    wrr(8'h22, cmd);
    chk("adc_pwr", {8'h00, pwr}, {8'h00, adc_pwr});
    n = 1;
    while (adc_pwr !== 2'b00 && n < 200) begin
      step(1);
      n++;
    end
    chk("conv_len", 10'h001, {9'h000, n >= 58 && n <= 67});
  endtask

  task automatic t_reset();
    chk("span", 10'h000, {8'h00, span});
    chk("dac_pwr", 10'h000, {7'h00, dac_pwr});
    chk("adc_pwr", 10'h000, {8'h00, adc_pwr});
    ticks(4);
  endtask

  task automatic t_dac();
    wrr(8'h25, 8'h01);
    chk("span", 10'h001, {8'h00, span});
    wrr(8'h25, 8'hc2);
    chk("span", 10'h002, {8'h00, span});
    wrr(8'h29, 8'h05);
    chk("dac_pwr", 10'h005, {7'h00, dac_pwr});
    wrr(8'h24, 8'hab);
    chk("dac_a", 10'h2af, dac_a);
    wrr(8'h28, 8'h80);
    wrr(8'h24, 8'h11);
    chk("dac_a", 10'h2af, dac_a);
    wrr(8'h28, 8'h81);
    chk("dac_a", 10'h047, dac_a);
    wrr(8'h28, 8'h00);
  endtask

  task automatic t_adc();
    smp_a = 10'h2c5;
    wrr(8'h23, 8'h02);
    conv(8'h01, 2'b01);
    rd(8'h2c, 8'hc5);
    rd(8'h2d, 8'h02);
    rd(8'h2a, 8'h00);
    wrr(8'h23, 8'h06);
    chk("sel_a", 10'h001, {9'h000, sel_a});
    smp_a = 10'h13a;
    smp_b = 10'h3ff;
    conv(8'h09, 2'b11);
    rd(8'h2a, 8'h3a);
    rd(8'h2b, 8'h01);
    rd(8'h2e, 8'hff);
    rd(8'h2f, 8'h03);
    rd(8'h2c, 8'hc5);
    rd(8'h40, 8'h00);
  endtask

  // reference fields, the two held update modes, and the external and serial-port start modes
  task automatic t_modes();
    wrr(8'h17, 8'hb7);
    chk("dac_fs", 10'h00b, {6'h00, fs_b, fs_a});
    chk("adc_ref", 10'h003, {8'h00, ref_en, ref_fs});
    wrr(8'h22, 8'h02);
    chk("ext_ref", 10'h003, {8'h00, route});
    wrr(8'h17, 8'h00);
    chk("ext_ref", 10'h001, {8'h00, route});
    wrr(8'h28, 8'h10);
    wrr(8'h26, 8'h80);
    chk("dac_b", 10'h000, dac_b);
    wrr(8'h28, 8'h10);
    chk("dac_b", 10'h200, dac_b);
    wrr(8'h28, 8'h20);
    wrr(8'h26, 8'h40);
    chk("dac_b", 10'h200, dac_b);
    txpd = 1'b1;
    step(5);
    chk("dac_b", 10'h100, dac_b);
    txpd = 1'b0;
    wrr(8'h28, 8'h00);
    smp_a = 10'h0f0;
    smp_b = 10'h00f;
    wrr(8'h23, 8'h12);
    exts = 1'b1;
    step(4);
    chk("adc_pwr", 10'h003, {8'h00, adc_pwr});
    exts = 1'b0;
    step(70);
    rd(8'h2c, 8'hf0);
    rd(8'h2e, 8'h0f);
    wrr(8'h23, 8'h22);
    wrr(8'h22, 8'h09);
    chk("adc_pwr", 10'h000, {8'h00, adc_pwr});
    wrr(8'h23, 8'h06);
  endtask

  // constant input keeps the mean exact whatever the sample count
  task automatic t_avg();
    smp_a = 10'h155;
    wrr(8'h18, 8'h08);
    wrr(8'h22, 8'h01);
    chk("adc_pwr", 10'h000, {8'h00, adc_pwr});
    wrr(8'h18, 8'h88);
    step(150);
    rd(8'h2a, 8'h55);
    wrr(8'h18, 8'h00);
    step(80);
    wrr(8'h23, 8'h01);
    ticks(8);
    wrr(8'h23, 8'h03);
    ticks(2);
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    step(12);
    rstn_i = 1'b1;
    step(1);
    t_reset();
    t_dac();
    t_adc();
    t_modes();
    t_avg();
    stop_test();
  end

  // watchdog far beyond the roughly six hundred cycles the tests need
  initial begin
    #100000;
    err_count++;
    stop_test();
  end
endmodule
